// [hw/vsd_params.svh]
`ifndef VSD_PARAMS_SVH
`define VSD_PARAMS_SVH

// Clock periods per line for 525-line and 625-line systems.
`define VSD_LINE_525        11'h6b4
`define VSD_LINE_625        11'h6c0
`define VSD_LINE_MAX        1728

// Line delay position width and sample width.
`define VSD_IDX_W           11
`define VSD_SAMPLE_W        9
`define VSD_MID             10'sh100

// Lines counted per field: above this split the source is a 625-line system.
`define VSD_FIELD_SPLIT     10'h120

// Frequencies in kHz: sample rate, class split, guard band and subcarriers.
`define VSD_LLC_KHZ         16'h6978
`define VSD_FSC_SPLIT_KHZ   16'h0fa0
`define VSD_FSC_GUARD_LO    16'h113a
`define VSD_FSC_GUARD_HI    16'h114e
`define VSD_FSC_PALSEC_KHZ  16'h1144
`define VSD_FSC_NTSC_M      16'h0dfc
`define VSD_FSC_PAL_M       16'h0df8
`define VSD_FSC_PAL_N       16'h0dfe
`define VSD_FSC_PAL_BG      16'h1152
`define VSD_FSC_SECAM       16'h1136

// Vertical transition thresholds of the adaptive comb.
`define VSD_TRANS_TH        12'h030
`define VSD_TRANS_TH2       12'h060

// Subcarrier oscillator phase width.
`define VSD_DDS_W           24

`endif

// [hw/vsd_pkg.sv]
package vsd_pkg;

  typedef logic [8:0]        vsd_sample_t;
  typedef logic signed [9:0] vsd_sdiff_t;

  typedef enum logic [2:0] {
    VSD_NTSC_M = 3'b000,
    VSD_PAL_M  = 3'b001,
    VSD_PAL_N  = 3'b010,
    VSD_PAL_BG = 3'b011,
    VSD_SECAM  = 3'b100,
    VSD_PAL_60 = 3'b101
  } vsd_std_e;

  typedef enum logic [1:0] {
    VSD_DET_WAIT   = 2'b00,
    VSD_DET_MEAS   = 2'b01,
    VSD_DET_DECIDE = 2'b10
  } vsd_det_e;

  typedef enum logic [1:0] {
    VSD_SEP_FULL   = 2'b00,
    VSD_SEP_HALF   = 2'b01,
    VSD_SEP_NOTCH  = 2'b10,
    VSD_SEP_BYPASS = 2'b11
  } vsd_sep_e;

endpackage

// [hw/vsd_line_delay.sv]
`timescale 1ns/10ps
`default_nettype none
`include "vsd_params.svh"
module vsd_line_delay
(
  // Clock and reset.
  input  wire logic                core_clk_i,
  input  wire logic                sys_rst_i,
  // Position within the line, shared by every delay.
  input  wire logic [10:0]         idx_i,
  // Samples in and one line later.
  input  wire vsd_pkg::vsd_sample_t din_i,
  output var  vsd_pkg::vsd_sample_t dout_o
);
  import vsd_pkg::*;

  vsd_sample_t mem [0:`VSD_LINE_MAX-1];

  // The old sample is read in the same edge that overwrites it, so the
  // delay is one line length of clocks plus one clock for the output register.
  always_ff @(posedge core_clk_i)
  begin
    mem[idx_i] <= din_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      dout_o <= '0;
    else
      dout_o <= mem[idx_i];
  end

endmodule
`default_nettype wire

// [hw/vsd_comb_decoder.sv]
`timescale 1ns/10ps
`default_nettype none
`include "vsd_params.svh"
module vsd_comb_decoder
(
  // Clock and reset; the clock is the line-locked sample clock.
  input  wire logic                core_clk_i,
  input  wire logic                sys_rst_i,
  // Converter samples.
  input  wire vsd_pkg::vsd_sample_t composite_video_input_i,
  input  wire vsd_pkg::vsd_sample_t chroma_adc_i,
  // Timing from the synchronisation recovery.
  input  wire logic                hsync_i,
  input  wire logic                vsync_i,
  input  wire logic                burst_gate_i,
  // Configuration.
  input  wire logic                yc_mode_i,
  input  wire logic                force_en_i,
  input  wire vsd_pkg::vsd_std_e    force_std_i,
  input  wire vsd_pkg::vsd_std_e    pref_std_i,
  // Decoded pixel stream.
  output var  vsd_pkg::vsd_sample_t y_o,
  output var  logic [8:0]          cb_o,
  output var  logic [8:0]          cr_o,
  output var  logic                pix_valid_o,
  // Detection status.
  output var  vsd_pkg::vsd_std_e    std_o,
  output var  logic                rate_50_o,
  output var  logic                std_locked_o
);
  import vsd_pkg::*;

  function automatic logic is_50(input vsd_std_e s);
    return (s == VSD_PAL_N) || (s == VSD_PAL_BG) || (s == VSD_SECAM);
  endfunction

  function automatic logic above(input logic [15:0] cr, input logic [15:0] ck, input logic [15:0] khz);
    return (32'(cr) * 32'(`VSD_LLC_KHZ)) > (32'(ck) * 32'(khz));
  endfunction

  function automatic logic signed [11:0] sx(input vsd_sample_t a);
    return 12'(vsd_sdiff_t'({1'b0, a}) - `VSD_MID);
  endfunction

  function automatic logic [11:0] absd(input logic signed [11:0] d);
    return d[11] ? 12'(-d) : 12'(d);
  endfunction

  function automatic vsd_sample_t ysat(input logic signed [10:0] l);
    logic signed [11:0] v;
    v = 12'(l) + 12'sh100;
    return v[11] ? 9'h000 : ((v[10:9] != 2'b00) ? 9'h1ff : v[8:0]);
  endfunction

  function automatic logic signed [7:0] sine(input logic [3:0] ph);
    logic [2:0]        q;
    logic signed [7:0] m;
    q = ph[2] ? (3'h4 - 3'(ph[1:0])) : 3'(ph[1:0]);
    unique case (q)
      3'h0:    m = 8'sh00;
      3'h1:    m = 8'sh31;
      3'h2:    m = 8'sh5a;
      3'h3:    m = 8'sh75;
      default: m = 8'sh7f;
    endcase
    return ph[3] ? -m : m;
  endfunction

  // The oscillator free-runs at the nominal subcarrier; it is not locked to
  // the burst, and SECAM's FM chroma is only roughly demodulated this way.
  function automatic logic [23:0] fsc_inc(input vsd_std_e s);
    logic [55:0] khz;
    khz = 56'(`VSD_FSC_PAL_BG);
    unique case (s)
      VSD_NTSC_M: khz = 56'(`VSD_FSC_NTSC_M);
      VSD_PAL_M:  khz = 56'(`VSD_FSC_PAL_M);
      VSD_PAL_N:  khz = 56'(`VSD_FSC_PAL_N);
      VSD_SECAM:  khz = 56'(`VSD_FSC_SECAM);
      default:    khz = 56'(`VSD_FSC_PAL_BG);
    endcase
    return 24'((khz << `VSD_DDS_W) / 56'(`VSD_LLC_KHZ));
  endfunction

  vsd_sample_t cv_q, ch_q, bprev;
  logic        dpos_q;

  // Burst slope detector, declared ahead of the register stage that keeps its last value.
  wire vsd_sample_t       bsrc   = yc_mode_i ? ch_q : cv_q;
  wire logic signed [9:0] bdiff  = $signed({1'b0, bsrc}) - $signed({1'b0, bprev});
  wire logic              dpos   = !bdiff[9] && (bdiff != 10'sh000);

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      cv_q   <= '0;
      ch_q   <= '0;
      bprev  <= '0;
      dpos_q <= 1'b0;
    end
    else
    begin
      cv_q   <= composite_video_input_i;
      ch_q   <= chroma_adc_i;
      bprev  <= yc_mode_i ? ch_q : cv_q;
      dpos_q <= dpos;
    end
  end

  // Subcarrier frequency: rising slopes per burst clock, over one field.
  vsd_det_e    det_st, next_det_st;
  vsd_std_e    std;
  logic        locked;
  logic [9:0]  line_cnt;
  logic [15:0] bclk, bcross;

  wire logic              meas   = det_st == VSD_DET_MEAS;
  wire logic              decide = det_st == VSD_DET_DECIDE;

  wire logic [9:0]  next_line_cnt = !meas ? 10'h000 : line_cnt + 10'(hsync_i && !(&line_cnt));
  wire logic [15:0] next_bclk     = !meas ? 16'h0000 : bclk + 16'(burst_gate_i && !(&bclk));
  wire logic [15:0] next_bcross   = !meas ? 16'h0000 : bcross + 16'(burst_gate_i && dpos && !dpos_q);

  wire logic f50    = line_cnt > `VSD_FIELD_SPLIT;
  wire logic hi     = above(bcross, bclk, `VSD_FSC_SPLIT_KHZ);
  wire logic pal_ns = above(bcross, bclk, `VSD_FSC_PALSEC_KHZ);
  wire logic guard  = above(bcross, bclk, `VSD_FSC_GUARD_LO) && !above(bcross, bclk, `VSD_FSC_GUARD_HI);
  wire logic pref_4 = (pref_std_i == VSD_PAL_BG) || (pref_std_i == VSD_SECAM);

  // The preferred standard only settles pairs that measurement cannot split.
  wire vsd_std_e std_4   = (guard && pref_4) ? pref_std_i : (pal_ns ? VSD_PAL_BG : VSD_SECAM);
  wire vsd_std_e std_60  = (pref_std_i == VSD_PAL_M) ? VSD_PAL_M : VSD_NTSC_M;
  wire vsd_std_e det_std = f50 ? (hi ? std_4 : VSD_PAL_N) : (hi ? VSD_PAL_60 : std_60);
  wire vsd_std_e next_std = force_en_i ? force_std_i : (decide ? det_std : std);
  wire logic next_locked  = force_en_i || decide || (locked && (det_st != VSD_DET_WAIT));

  always_comb
  begin
    next_det_st = det_st;
    unique case (det_st)
      VSD_DET_WAIT:   if (vsync_i) next_det_st = VSD_DET_MEAS;
      VSD_DET_MEAS:   if (vsync_i) next_det_st = VSD_DET_DECIDE;
      VSD_DET_DECIDE: next_det_st = VSD_DET_MEAS;
      default:        next_det_st = VSD_DET_WAIT;
    endcase
  end

  // Shared line position: every delay line reads and writes here.
  logic [10:0] wr_idx;
  wire logic [10:0] line_len    = is_50(std) ? `VSD_LINE_625 : `VSD_LINE_525;
  wire logic        wrap        = wr_idx >= (line_len - 11'h001);
  wire logic [10:0] next_wr_idx = wrap ? 11'h000 : wr_idx + 11'h001;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      det_st   <= VSD_DET_WAIT;
      std      <= VSD_NTSC_M;
      locked   <= 1'b0;
      line_cnt <= '0;
      bclk     <= '0;
      bcross   <= '0;
      wr_idx   <= '0;
    end
    else
    begin
      det_st   <= next_det_st;
      std      <= next_std;
      locked   <= next_locked;
      line_cnt <= next_line_cnt;
      bclk     <= next_bclk;
      bcross   <= next_bcross;
      wr_idx   <= next_wr_idx;
    end
  end

  assign std_o        = std;
  assign rate_50_o    = is_50(std);
  assign std_locked_o = locked;

  // Taps: tap[0] is the newest line, tap[3] three lines older.
  wire [8:0] tap [0:3];
  assign tap[0] = cv_q;

  genvar k;
  generate
    for (k = 0; k < 3; k++)
    begin : g_dly
      vsd_line_delay u_dly
      (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .idx_i      (wr_idx),
        .din_i      (tap[k]),
        .dout_o     (tap[k+1])
      );
    end
  endgenerate

  vsd_sample_t z [0:3];
  vsd_sample_t c_z2;

  always_ff @(posedge core_clk_i)
  begin
    for (int i = 0; i < 4; i++)
      z[i] <= sys_rst_i ? 9'h000 : tap[i];
    c_z2 <= sys_rst_i ? 9'h000 : z[1];
  end

  wire logic pal = (std == VSD_PAL_M) || (std == VSD_PAL_N) || (std == VSD_PAL_BG) || (std == VSD_PAL_60);
  wire logic signed [11:0] s0 = sx(z[0]);
  wire logic signed [11:0] s1 = sx(z[1]);
  wire logic signed [11:0] s2 = sx(z[2]);
  wire logic signed [11:0] s3 = sx(z[3]);

  // Chroma-free vertical change: equal-phase lines for NTSC, opposite pairs for PAL.
  wire logic [11:0] vt       = pal ? absd((s0 + s2) - (s1 + s3)) : absd(s0 - s2);
  wire logic        trans_lo = vt >= `VSD_TRANS_TH;
  wire logic        trans_hi = vt >= `VSD_TRANS_TH2;

  wire vsd_sep_e sep = yc_mode_i ? VSD_SEP_BYPASS :
                       ((std == VSD_SECAM) || trans_hi || (pal && trans_lo)) ? VSD_SEP_NOTCH :
                       trans_lo ? VSD_SEP_HALF : VSD_SEP_FULL;

  wire logic signed [11:0] c_n3    = ((s1 <<< 1) - s0 - s2) >>> 2;
  wire logic signed [11:0] c_n2    = (s1 - s0) >>> 1;
  wire logic signed [11:0] c_pal   = (s1 - s3) >>> 1;
  wire logic signed [11:0] c_notch = ((s1 <<< 1) - sx(tap[1]) - sx(c_z2)) >>> 2;

  wire logic signed [11:0] c_w = (sep == VSD_SEP_BYPASS) ? sx(ch_q) :
                                 (sep == VSD_SEP_NOTCH) ? c_notch :
                                 (sep == VSD_SEP_HALF) ? c_n2 :
                                 pal ? c_pal : c_n3;
  wire logic signed [11:0] l_src  = (sep == VSD_SEP_BYPASS) ? sx(cv_q) : s1;
  wire logic signed [10:0] luma_w = 11'(l_src - ((sep == VSD_SEP_BYPASS) ? 12'sh000 : c_w));
  wire logic signed [9:0]  c10    = 10'(c_w);

  logic [23:0]            phase;
  logic signed [10:0]     luma1;
  logic signed [17:0]     pu, pv, pu_q, pv_q;
  wire logic signed [18:0] su = 19'(pu) + 19'(pu_q);
  wire logic signed [18:0] sv = 19'(pv) + 19'(pv_q);

  // Luma and chroma both pass two registers after the tap stage.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      phase       <= '0;
      luma1       <= '0;
      {pu, pv}    <= '0;
      {pu_q, pv_q} <= '0;
      y_o         <= '0;
      cb_o        <= '0;
      cr_o        <= '0;
      pix_valid_o <= 1'b0;
    end
    else
    begin
      phase       <= phase + fsc_inc(std);
      luma1       <= luma_w;
      pu          <= c10 * sine(phase[23:20]);
      pv          <= c10 * sine(phase[23:20] + 4'h4);
      pu_q        <= pu;
      pv_q        <= pv;
      y_o         <= ysat(luma1);
      cb_o        <= 9'(su >>> 9);
      cr_o        <= 9'(sv >>> 9);
      pix_valid_o <= locked;
    end
  end

  property p_line_525;
    @(posedge core_clk_i) disable iff (sys_rst_i) (!is_50(std) && wr_idx == 11'h6b3) |=> (wr_idx == 11'h000);
  endproperty
  a_line_525: assert property (p_line_525) else $error("525-line delay did not wrap at 1716");

  property p_rate;
    @(posedge core_clk_i) disable iff (sys_rst_i) (decide && !force_en_i) |=> (rate_50_o == $past(f50));
  endproperty
  a_rate: assert property (p_rate) else $error("field rate class wrong after decision");

  property p_colour;
    @(posedge core_clk_i) disable iff (sys_rst_i) (decide && !force_en_i && f50 && !hi) |=> (std_o == VSD_PAL_N);
  endproperty
  a_colour: assert property (p_colour) else $error("low subcarrier at 50 Hz not PAL N");

  property p_force;
    @(posedge core_clk_i) disable iff (sys_rst_i) force_en_i |=> (std_o == $past(force_std_i)) && std_locked_o;
  endproperty
  a_force: assert property (p_force) else $error("forced standard not applied");

  property p_ntsc3;
    @(posedge core_clk_i) disable iff (sys_rst_i) (!yc_mode_i && std == VSD_NTSC_M && !trans_lo) |-> (sep == VSD_SEP_FULL);
  endproperty
  a_ntsc3: assert property (p_ntsc3) else $error("NTSC still picture not three-line combed");

  property p_pal;
    @(posedge core_clk_i) disable iff (sys_rst_i) (!yc_mode_i && pal && trans_lo) |-> (sep == VSD_SEP_NOTCH);
  endproperty
  a_pal: assert property (p_pal) else $error("PAL transition kept combing");

  property p_adapt;
    @(posedge core_clk_i) disable iff (sys_rst_i) (!yc_mode_i && std == VSD_NTSC_M && trans_lo && !trans_hi) |-> (sep == VSD_SEP_HALF);
  endproperty
  a_adapt: assert property (p_adapt) else $error("transition did not reduce comb");

  property p_count;
    @(posedge core_clk_i) disable iff (sys_rst_i) !wrap |=> (wr_idx == $past(wr_idx) + 11'h001);
  endproperty
  a_count: assert property (p_count) else $error("line position skipped a clock");

  property p_split;
    @(posedge core_clk_i) disable iff (sys_rst_i) (sep != VSD_SEP_BYPASS) |-> (12'(luma_w) + c_w == s1);
  endproperty
  a_split: assert property (p_split) else $error("luma plus chroma differs from input");

  property p_align;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (c_w == 12'sh000) ##1 (c_w == 12'sh000) |-> ##2 (cb_o == 9'h000 && cr_o == 9'h000 && y_o == ysat($past(luma_w, 2)));
  endproperty
  a_align: assert property (p_align) else $error("luma and chroma paths misaligned");

endmodule
`default_nettype wire

// [bench/vsd_video_src.sv]
`timescale 1ns/10ps
`default_nettype none
module vsd_video_src
#(
  parameter int LINE_LEN = 12
)
(
  // Clock; every output moves on its falling edge.
  input  wire logic                 core_clk_i,
  // Source settings.
  input  wire logic                 wave_en_i,
  input  wire logic [3:0]           per_i,
  input  wire logic                 alt_i,
  input  wire logic [9:0]           lines_i,
  input  wire vsd_pkg::vsd_sample_t level_i,
  // Converter samples and timing.
  output var  vsd_pkg::vsd_sample_t cv_o,
  output var  vsd_pkg::vsd_sample_t ch_o,
  output var  logic                 hsync_o,
  output var  logic                 vsync_o,
  output var  logic                 burst_o
);
  import vsd_pkg::*;
  int         pos  = 0;
  int         line = 0;
  int         ph   = 0;
  logic       odd  = 1'b0;
  logic [3:0] cur_per;
  logic       line_end;
  logic       field_end;

  // Short lines keep a field cheap; the detector only counts sync pulses.
  assign cur_per   = per_i + {3'h0, alt_i & odd};
  assign line_end  = (pos == LINE_LEN - 1);
  assign field_end = line_end && (line >= int'(lines_i) - 1);

  initial
  begin
    cv_o    = 9'h100;
    ch_o    = 9'h100;
    hsync_o = 1'b0;
    vsync_o = 1'b0;
    burst_o = 1'b0;
  end

  // The square wave runs with continuous phase, so the burst rate is exact over a field.
  always @(negedge core_clk_i)
  begin
    pos     <= line_end ? 0 : pos + 1;
    hsync_o <= line_end;
    vsync_o <= field_end;
    burst_o <= wave_en_i;
    if (line_end)
      line <= field_end ? 0 : line + 1;
    if (ph >= int'(cur_per) - 1)
    begin
      ph  <= 0;
      odd <= !odd;
    end
    else
      ph <= ph + 1;
    cv_o <= !wave_en_i ? level_i : (ph < int'(cur_per) / 2) ? 9'h140 : 9'h0c0;
    ch_o <= 9'h100;
  end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import vsd_pkg::*;
  localparam int CYC_LIMIT = 80000;
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        yc_mode    = 1'b0;
  logic        force_en   = 1'b0;
  vsd_std_e    force_std  = VSD_NTSC_M;
  vsd_std_e    pref_std   = VSD_NTSC_M;
  logic        wave_en    = 1'b0;
  logic [3:0]  per        = 4'h6;
  logic        alt        = 1'b0;
  logic [9:0]  lines      = 10'h138;
  vsd_sample_t level      = 9'h100;
  vsd_sample_t cv;
  vsd_sample_t ch;
  logic        hsync;
  logic        vsync;
  logic        burst;
  vsd_sample_t y;
  logic [8:0]  cb;
  logic [8:0]  cr;
  logic        pix_valid;
  vsd_std_e    std;
  logic        rate_50;
  logic        std_locked;
  int          err_count  = 0;
  int          cmp_count  = 0;
  int          cyc_count  = 0;

  vsd_video_src #(.LINE_LEN(12)) i_src (
    .core_clk_i(core_clk_i), .wave_en_i(wave_en), .per_i(per), .alt_i(alt), .lines_i(lines),
    .level_i(level), .cv_o(cv), .ch_o(ch), .hsync_o(hsync), .vsync_o(vsync), .burst_o(burst));

  vsd_comb_decoder i_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .composite_video_input_i(cv), .chroma_adc_i(ch),
    .hsync_i(hsync), .vsync_i(vsync), .burst_gate_i(burst), .yc_mode_i(yc_mode),
    .force_en_i(force_en), .force_std_i(force_std), .pref_std_i(pref_std), .y_o(y), .cb_o(cb),
    .cr_o(cr), .pix_valid_o(pix_valid), .std_o(std), .rate_50_o(rate_50), .std_locked_o(std_locked));

  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == CYC_LIMIT)
    begin
      err_count = err_count + 1;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_vsync;
    do @(posedge core_clk_i); while (vsync !== 1'b1);
  endtask

  task automatic t_reset;
    chk("y", y, 9'h000);
    chk("cb", cb, 9'h000);
    chk("cr", cr, 9'h000);
    chk("std", {6'h00, std}, {6'h00, VSD_NTSC_M});
    chk("rate", {8'h00, rate_50}, 9'h000);
    chk("locked", {8'h00, std_locked}, 9'h000);
    chk("valid", {8'h00, pix_valid}, 9'h000);
    $display("test reset done");
  endtask

  // A forced standard holds even while the detector sees a different source.
  task automatic t_force;
    vsd_std_e c;
    force_en <= 1'b1;
    @(negedge core_clk_i);
    chk("locked", {8'h00, std_locked}, 9'h001);
    chk("valid", {8'h00, pix_valid}, 9'h000);
    @(negedge core_clk_i);
    chk("valid", {8'h00, pix_valid}, 9'h001);
    for (int i = 0; i < 6; i++)
    begin
      c = vsd_std_e'(i[2:0]);
      force_std <= c;
      @(negedge core_clk_i);
      chk("std", {6'h00, std}, {6'h00, c});
      chk("rate", {8'h00, rate_50}, {8'h00, c == VSD_PAL_N || c == VSD_PAL_BG || c == VSD_SECAM});
    end
    force_std <= VSD_PAL_M;
    wave_en   <= 1'b1;
    wait_vsync();
    wait_vsync();
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("std", {6'h00, std}, {6'h00, VSD_PAL_M});
    force_en <= 1'b0;
    $display("test force done");
  endtask

  // Settings land just after a field start, so the next closing sync judges a clean field.
  task automatic t_detect(input logic [9:0] n, input logic [3:0] p, input logic a,
                          input vsd_std_e pref, input vsd_std_e exp);
    lines    <= n;
    per      <= p;
    alt      <= a;
    pref_std <= pref;
    wait_vsync();
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("std", {6'h00, std}, {6'h00, exp});
    chk("rate", {8'h00, rate_50}, {8'h00, n > 10'h120});
    chk("locked", {8'h00, std_locked}, 9'h001);
    $display("test detect %0d done", exp);
  endtask

  // A flat picture carries no chroma, so the bypass and the full comb must both hand back the level.
  task automatic t_pix(input vsd_std_e s);
    force_en  <= 1'b1;
    force_std <= s;
    wave_en   <= 1'b0;
    level     <= 9'h12c;
    yc_mode   <= 1'b1;
    repeat (4) @(negedge core_clk_i);
    chk("y", y, 9'h12c);
    chk("cb", cb, 9'h000);
    chk("cr", cr, 9'h000);
    yc_mode <= 1'b0;
    repeat (4 * 1728 + 20) @(negedge core_clk_i);
    chk("y", y, 9'h12c);
    chk("cb", cb, 9'h000);
    chk("cr", cr, 9'h000);
    $display("test pixel %0d done", s);
  endtask

  initial
  begin
    repeat (8) @(negedge core_clk_i);
    t_reset();
    sys_rst_i <= 1'b0;
    @(negedge core_clk_i);
    t_force();
    wait_vsync();
    @(negedge core_clk_i);
    t_detect(10'h138, 4'h6, 1'b0, VSD_NTSC_M, VSD_PAL_BG);
    t_detect(10'h138, 4'h6, 1'b1, VSD_NTSC_M, VSD_SECAM);
    t_detect(10'h138, 4'h7, 1'b0, VSD_NTSC_M, VSD_PAL_N);
    t_detect(10'h106, 4'h7, 1'b0, VSD_NTSC_M, VSD_NTSC_M);
    t_detect(10'h106, 4'h7, 1'b0, VSD_PAL_M, VSD_PAL_M);
    t_detect(10'h106, 4'h6, 1'b0, VSD_NTSC_M, VSD_PAL_60);
    t_pix(VSD_NTSC_M);
    t_pix(VSD_PAL_BG);
    test_done();
  end
endmodule
`default_nettype wire
